/* File: tb/fpx_link_model.sv */
// Medium-side link model: receive clock, symbol pairs and byte clock
`timescale 1ns/1ns
module fpx_link_model (
  input  wire logic       clk,
  output logic            recovered_rx_clock,
  output logic      [9:0] rx_pair_in,
  output logic            local_byte_clock
);
  logic [9:0] pair_q [$];
  logic       hold_byte;
  logic       in_frame;
  logic [2:0] phase;

  initial begin
    recovered_rx_clock = 1'b0;
    rx_pair_in         = 10'h000;
    local_byte_clock   = 1'b0;
    hold_byte          = 1'b0;
    in_frame           = 1'b0;
    phase              = 3'h0;
  end

  // Pair set four cycles before the clock rises, held four after
  always @(posedge clk) begin
    phase <= phase + 3'h1;
    if (phase == 3'h0) begin
      recovered_rx_clock <= 1'b0;
      in_frame <= (pair_q.size() > 0);
      if (pair_q.size() > 0)
        rx_pair_in <= pair_q.pop_front();
      else
        rx_pair_in <= ~rx_pair_in;
    end
    if (phase == 3'h4 && in_frame)
      recovered_rx_clock <= 1'b1;
    if (phase == 3'h2 && !hold_byte)
      local_byte_clock <= 1'b1;
    if (phase == 3'h6)
      local_byte_clock <= 1'b0;
  end
endmodule : fpx_link_model

/* File: tb/fpx_top_checker.sv */
// Port assertions for the receive/transmit front
`timescale 1ns/1ns
module fpx_top_checker (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        local_byte_clock,
  input wire logic        rx_out_valid,
  input wire logic [9:0]  tx_word_in,
  input wire logic        tx_word_valid,
  input wire logic [9:0]  tx_medium_code,
  input wire logic        tx_medium_valid,
  input wire logic        tx_ext_loop_valid,
  input wire logic        tx_parity_fail
);
  logic [4:0] enc_tab [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                               5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_parity_cause: assert property (tx_parity_fail |-> $past(tx_word_valid) && !(^$past(tx_word_in)))
    else $error("parity fail without bad word");
  a_parity_pulse: assert property (tx_parity_fail |=> !tx_parity_fail)
    else $error("parity fail not a pulse");
  a_good_silent: assert property (tx_word_valid && (^tx_word_in) |=> !tx_parity_fail)
    else $error("parity fail on odd word");
  a_medium_delay: assert property (tx_medium_valid |-> $past(tx_word_valid, 2))
    else $error("medium output without word");
  a_data_encode: assert property (tx_medium_valid && !$past(tx_word_in[8], 2) |->
    tx_medium_code == {enc_tab[$past(tx_word_in[7:4], 2)], enc_tab[$past(tx_word_in[3:0], 2)]})
    else $error("data encoding wrong");
  a_route_exclusive: assert property (!(tx_medium_valid && tx_ext_loop_valid))
    else $error("two routes at once");
  a_byte_read: assert property ($rose(local_byte_clock) |-> ##[3:5] rx_out_valid)
    else $error("byte clock edge without read");
endmodule : fpx_top_checker

bind fpx_top fpx_top_checker u_fpx_top_checker (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .local_byte_clock, .rx_out_valid, .tx_word_in, .tx_word_valid, .tx_medium_code,
  .tx_medium_valid, .tx_ext_loop_valid, .tx_parity_fail);

/* File: tb/testbench.sv */
// Self-checking bench for the receive/transmit front
`timescale 1ns/1ns
`include "fpx_params.svh"
module testbench;
  logic        clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, signal_detect;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0]  wb_sel_i;
  logic        recovered_rx_clock, local_byte_clock, rx_out_tag, rx_out_valid, irq_n;
  logic [9:0]  rx_pair_in, rx_out_pair, tx_word_in, tx_medium_code, tx_ext_loop_code, got_code;
  logic        tx_word_valid, tx_medium_valid, tx_ext_loop_valid, tx_parity_fail;
  logic        got_pf, got_mv, got_ev;
  logic [10:0] seen_out;
  int          n_fail, cmp_count, cycles;
  logic [4:0]  enc [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

  fpx_top u_fpx_top (.clk, .reset, .clk_en(1'b1), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .recovered_rx_clock, .rx_pair_in, .signal_detect,
    .local_byte_clock, .rx_out_pair, .rx_out_tag, .rx_out_valid, .tx_word_in, .tx_word_valid,
    .tx_medium_code, .tx_medium_valid, .tx_ext_loop_code, .tx_ext_loop_valid, .tx_parity_fail,
    .irq_n);
  fpx_link_model u_link (.clk, .recovered_rx_clock, .rx_pair_in, .local_byte_clock);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      final_report();
    end
  end

  // Last tagged byte seen on the receive output
  always @(posedge clk) begin
    if (rx_out_valid && rx_out_tag)
      seen_out <= {rx_out_tag, rx_out_pair};
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(q, exp);
  endtask : rdchk

  function automatic logic [9:0] word(input logic c, input logic [7:0] d);
    return {~^{c, d}, c, d};
  endfunction : word

  task automatic tx(input logic [9:0] w);
    tx_word_in    <= w;
    tx_word_valid <= 1'b1;
    @(posedge clk);
    tx_word_valid <= 1'b0;
    @(negedge clk);
    got_pf = tx_parity_fail;
    @(negedge clk);
    got_mv = tx_medium_valid;
    got_ev = tx_ext_loop_valid;
    got_code = tx_medium_valid ? tx_medium_code : tx_ext_loop_code;
    @(posedge clk);
  endtask : tx

  task automatic rx(input logic [9:0] p, input int n);
    int k;
    for (k = 0; k < n; k++)
      u_link.pair_q.push_back(p);
    while (u_link.pair_q.size() > 0)
      @(posedge clk);
    repeat (12) @(posedge clk);
  endtask : rx

  task automatic t_reset;
    rdchk(`FPX_ADR_MODE, 32'h00);
    rdchk(`FPX_ADR_INT_MASK, 32'h11);
    rdchk(`FPX_ADR_LE_THRESH, 32'hFF);
    rdchk(`FPX_ADR_LINE_STATE, 32'h0C);
    rdchk(8'h20, 32'h00);
    check(32'(irq_n), 32'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_line;
    signal_detect <= 1'b1;
    wb(1'b1, `FPX_ADR_MODE, 32'h01);
    rx(10'h000, 8);
    rdchk(`FPX_ADR_LINE_STATE, 32'h02);
    rx(10'h3FF, 2);
    rdchk(`FPX_ADR_LINE_STATE, 32'h01);
    rx(10'h311, 1);
    rx(10'h3C9, 3);
    rdchk(`FPX_ADR_LINE_STATE, 32'h00);
    rx(10'h021, 1);
    wb(1'b0, `FPX_ADR_LINE_STATE, 32'h0);
    check(32'(q[3]), 32'h1);
    rx(10'h021, 16);
    wb(1'b0, `FPX_ADR_LINE_STATE, 32'h0);
    check(32'(q[2:0]), 32'h3);
    wb(1'b1, `FPX_ADR_MODE, 32'h00);
    rdchk(`FPX_ADR_LINE_STATE, 32'h0C);
    wb(1'b1, `FPX_ADR_MODE, 32'h01);
    $display("test line states done");
  endtask : t_line

  task automatic t_lem;
    rx(10'h3FF, 2);
    wb(1'b1, `FPX_ADR_LE_THRESH, 32'h05);
    for (int i = 0; i < 5; i++) begin
      rx(10'h021, 1);
      rx(10'h3FF, 2);
    end
    rdchk(`FPX_ADR_INT_COND, 32'h10);
    check(32'(irq_n), 32'h0);
    rdchk(`FPX_ADR_LE_COUNT, 32'h00);
    rdchk(`FPX_ADR_LE_COUNT, 32'hFF);
    wb(1'b1, `FPX_ADR_INT_COND, 32'h10);
    rdchk(`FPX_ADR_INT_COND, 32'h00);
    check(32'(irq_n), 32'h1);
    wb(1'b1, `FPX_ADR_LE_THRESH, 32'hFF);
    $display("test link errors done");
  endtask : t_lem

  task automatic t_elastic;
    u_link.hold_byte <= 1'b1;
    repeat (8) @(posedge clk);
    seen_out <= 11'h000;
    wb(1'b1, `FPX_ADR_RX_COND_B, 32'h20);
    rdchk(`FPX_ADR_RX_COND_B, 32'h00);
    rx(10'h311, 1);
    rx(10'h3C9, 12);
    rdchk(`FPX_ADR_RX_COND_B, 32'h20);
    wb(1'b1, `FPX_ADR_RX_COND_B, 32'h20);
    rdchk(`FPX_ADR_RX_COND_B, 32'h00);
    u_link.hold_byte <= 1'b0;
    rx(10'h3FF, 4);
    repeat (100) @(posedge clk);
    check(32'(seen_out), 32'h7FF);
    $display("test elastic buffer done");
  endtask : t_elastic

  task automatic t_tx;
    wb(1'b1, `FPX_ADR_TX_STATE, 32'h40);
    for (int i = 0; i < 16; i++) begin
      tx(word(1'b0, {4'(i), 4'(15 - i)}));
      check(32'({got_mv, got_pf, got_code}), 32'({2'b10, enc[i], enc[15 - i]}));
    end
    tx(word(1'b1, 8'hDD));
    check(32'(got_code), 32'({5'h18, 5'h11}));
    tx(word(1'b1, 8'h44));
    check(32'(got_code), 32'({5'h0D, 5'h0D}));
    tx(word(1'b0, 8'h5A) ^ 10'h200);
    check(32'(got_pf), 32'h1);
    rdchk(`FPX_ADR_INT_COND, 32'h01);
    check(32'(irq_n), 32'h0);
    wb(1'b1, `FPX_ADR_INT_COND, 32'h01);
    check(32'(irq_n), 32'h1);
    wb(1'b1, `FPX_ADR_TX_STATE, 32'h00);
    tx(word(1'b0, 8'h5A) ^ 10'h200);
    check(32'(got_pf), 32'h0);
    rdchk(`FPX_ADR_INT_COND, 32'h00);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_route;
    wb(1'b1, `FPX_ADR_MODE, 32'h03);
    tx(word(1'b0, 8'h12));
    check(32'({got_mv, got_ev}), 32'h0);
    tx(word(1'b1, 8'hDD));
    rdchk(`FPX_ADR_LINE_STATE, 32'h00);
    wb(1'b1, `FPX_ADR_MODE, 32'h05);
    tx(word(1'b0, 8'h12));
    check(32'({got_mv, got_ev, got_code}), 32'({2'b01, 5'h09, 5'h14}));
    wb(1'b1, `FPX_ADR_MODE, 32'h01);
    $display("test routing done");
  endtask : t_route

  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, signal_detect, tx_word_valid} = 5'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hF;
    tx_word_in = 10'h000;
    n_fail = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_line();
    t_lem();
    t_elastic();
    t_tx();
    t_route();
    final_report();
  end
endmodule : testbench

/* File: verilog/fpx_params.svh */
// Register offsets, field positions, reset values and counts for the receive/transmit front
`ifndef FPX_PARAMS_SVH
`define FPX_PARAMS_SVH

`define FPX_ADR_MODE        8'h00
`define FPX_ADR_INT_COND    8'h04
`define FPX_ADR_INT_MASK    8'h08
`define FPX_ADR_TX_STATE    8'h0C
`define FPX_ADR_RX_COND_B   8'h10
`define FPX_ADR_LE_THRESH   8'h14
`define FPX_ADR_LE_COUNT    8'h18
`define FPX_ADR_LINE_STATE  8'h1C

`define FPX_BIT_RUN         0
`define FPX_BIT_LOOP_LO     1
`define FPX_BIT_LOOP_HI     2
`define FPX_LOOP_NORMAL     2'h0
`define FPX_LOOP_INTERNAL   2'h1
`define FPX_LOOP_EXTERNAL   2'h2
`define FPX_BIT_PARITY_ERR  0
`define FPX_BIT_LE_HIT      4
`define FPX_BIT_EB_FLAG     5
`define FPX_BIT_PARITY_EN   6
`define FPX_BIT_UNKNOWN     3

`define FPX_RST_MODE        8'h00
`define FPX_RST_INT_MASK    8'h11
`define FPX_RST_TX_STATE    8'h00
`define FPX_RST_LE_THRESH   8'hFF
`define FPX_LE_RELOAD       8'hFF

`define FPX_QUIET_PAIRS     4'h8
`define FPX_IDLE_PAIRS      4'h2
`define FPX_HALT_PAIRS      4'h8
`define FPX_MASTER_PAIRS    4'h8
`define FPX_NOISE_PAIRS     5'h10
`define FPX_RECENTRE_BYTES  2'h3

`define FPX_SYM_QUIET       5'h00
`define FPX_SYM_IDLE        5'h1F
`define FPX_SYM_HALT        5'h04
`define FPX_SYM_J           5'h18
`define FPX_SYM_K           5'h11
`define FPX_SYM_T           5'h0D
`define FPX_SYM_R           5'h07
`define FPX_SYM_S           5'h19

`endif

/* File: verilog/fpx_pkg.sv */
// Types shared by the receive/transmit front
package fpx_pkg;
  typedef enum logic [2:0] {
    fpx_ls_active, fpx_ls_idle, fpx_ls_quiet, fpx_ls_noise,
    fpx_ls_nosig, fpx_ls_master, fpx_ls_halt
  } fpx_ls_t;

  typedef enum logic [2:0] {
    fpx_cls_jk, fpx_cls_data, fpx_cls_idle, fpx_cls_quiet,
    fpx_cls_halt, fpx_cls_hq, fpx_cls_noise
  } fpx_cls_t;
endpackage : fpx_pkg

/* File: verilog/fpx_top.sv */
// Line state detector, elasticity buffer, link error monitor and transmit encoder front
//
// Summary of operation
// - Eight consecutive quiet pairs enter quiet state
// - Sixteen noise pairs without known state: noise
// - One inconsistent pair reports line state unknown
// - Byte FIFO written on receive, read on byte clock
// - Skew not absorbed sets elastic flag bit five
// - Depth sized for 50 ppm over 4500 bytes
// - Compensate only by idle pairs in preamble
// - Recentre on JK and every four idle bytes (code: every fourth byte read in any line state other than active)
// - Never share an entry; flag and tag early
// - Link errors decrement 8-bit counter in active/idle
// - Counter zero sets threshold flag, interrupt low
// - Count read returns value, reloads FF
// - Run low forces no signal and unknown
// - Transmit word: parity, control, two symbols
// - Odd parity; control flag selects data or control
// - Enabled parity failure sets flag, tells filter
// - Encode symbols to standard five-bit codes
// - Route code to medium, receiver or recovery
// - JK enters active, held through frame symbols
//
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
`include "fpx_params.svh"

module fpx_top #(
  parameter int EB_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        recovered_rx_clock,
  input  wire logic [9:0]  rx_pair_in,
  input  wire logic        signal_detect,
  input  wire logic        local_byte_clock,
  output logic      [9:0]  rx_out_pair,
  output logic             rx_out_tag,
  output logic             rx_out_valid,
  input  wire logic [9:0]  tx_word_in,
  input  wire logic        tx_word_valid,
  output logic      [9:0]  tx_medium_code,
  output logic             tx_medium_valid,
  output logic      [9:0]  tx_ext_loop_code,
  output logic             tx_ext_loop_valid,
  output logic             tx_parity_fail,
  output logic             irq_n
);
  localparam int AW   = $clog2(EB_DEPTH);
  localparam int HALF = EB_DEPTH / 2;

  // Depth must be a power of two of at least four for pointer wrap and recentring
  generate
    if (EB_DEPTH < 4 || (1 << AW) != EB_DEPTH) begin : g_bad_depth
      $error("fpx_top: EB_DEPTH must be a power of two, at least 4");
    end
  endgenerate

  typedef struct packed {
    logic                      rxc_s1;
    logic                      rxc_s2;
    logic                      rxc_s3;
    logic                      lbc_s1;
    logic                      lbc_s2;
    logic                      lbc_s3;
    logic                      sd_s1;
    logic                      sd_s2;
    logic [9:0]                pair_s1;
    logic [9:0]                pair_s2;
    logic                      ack;
    logic [31:0]               rdata;
    logic [7:0]                mode;
    logic [7:0]                interrupt_condition;
    logic [7:0]                mask;
    logic [7:0]                transmit_state_control;
    logic [7:0]                receive_condition_b;
    logic [7:0]                link_error_threshold;
    logic [7:0]                lem;
    fpx_pkg::fpx_ls_t          ls;
    logic                      unknown;
    fpx_pkg::fpx_cls_t         last_cls;
    logic [3:0]                same_cnt;
    logic [4:0]                noise_cnt;
    logic [EB_DEPTH-1:0][10:0] mem;
    logic [AW-1:0]             wp;
    logic [AW-1:0]             rp;
    logic [AW:0]               fill;
    logic                      tag_pend;
    logic [1:0]                rc_cnt;
    logic                      last_idle;
    logic [9:0]                out_pair;
    logic                      out_tag;
    logic                      out_valid;
    logic [9:0]                tx_code;
    logic                      tx_valid;
    logic [9:0]                med_code;
    logic                      med_valid;
    logic [9:0]                ext_code;
    logic                      ext_valid;
    logic                      par_fail;
    logic                      irq_n;
  } fpx_state_t;

  fpx_state_t st_reg;
  fpx_state_t st_next;

  function automatic logic [4:0] enc5(input logic [3:0] nib);
    case (nib)
      4'h0:    enc5 = 5'h1E;
      4'h1:    enc5 = 5'h09;
      4'h2:    enc5 = 5'h14;
      4'h3:    enc5 = 5'h15;
      4'h4:    enc5 = 5'h0A;
      4'h5:    enc5 = 5'h0B;
      4'h6:    enc5 = 5'h0E;
      4'h7:    enc5 = 5'h0F;
      4'h8:    enc5 = 5'h12;
      4'h9:    enc5 = 5'h13;
      4'hA:    enc5 = 5'h16;
      4'hB:    enc5 = 5'h17;
      4'hC:    enc5 = 5'h1A;
      4'hD:    enc5 = 5'h1B;
      4'hE:    enc5 = 5'h1C;
      default: enc5 = 5'h1D;
    endcase
  endfunction : enc5

  // Control nibble to code; JK depends on position in the pair
  function automatic logic [4:0] ctl5(input logic [3:0] nib, input logic second);
    case (nib)
      4'h0:    ctl5 = `FPX_SYM_IDLE;
      4'h1:    ctl5 = `FPX_SYM_HALT;
      4'h2:    ctl5 = `FPX_SYM_QUIET;
      4'h4:    ctl5 = `FPX_SYM_T;
      4'h5:    ctl5 = `FPX_SYM_T;
      4'h6:    ctl5 = `FPX_SYM_R;
      4'h7:    ctl5 = `FPX_SYM_S;
      4'hA:    ctl5 = `FPX_SYM_IDLE;
      4'hD:    ctl5 = second ? `FPX_SYM_K : `FPX_SYM_J;
      default: ctl5 = `FPX_SYM_HALT;
    endcase
  endfunction : ctl5

  function automatic logic frame_sym(input logic [4:0] s);
    logic ok;
    ok = (s == `FPX_SYM_T) || (s == `FPX_SYM_R) || (s == `FPX_SYM_S);
    for (int i = 0; i < 16; i++) begin
      if (enc5(4'(i)) == s) begin
        ok = 1'b1;
      end
    end
    frame_sym = ok;
  endfunction : frame_sym

  function automatic fpx_pkg::fpx_cls_t classify(input logic [9:0] p);
    logic [4:0] hi;
    logic [4:0] lo;
    hi = p[9:5];
    lo = p[4:0];
    if (hi == `FPX_SYM_J && lo == `FPX_SYM_K) begin
      classify = fpx_pkg::fpx_cls_jk;
    end else if (hi == `FPX_SYM_QUIET && lo == `FPX_SYM_QUIET) begin
      classify = fpx_pkg::fpx_cls_quiet;
    end else if (hi == `FPX_SYM_IDLE && lo == `FPX_SYM_IDLE) begin
      classify = fpx_pkg::fpx_cls_idle;
    end else if (hi == `FPX_SYM_HALT && lo == `FPX_SYM_HALT) begin
      classify = fpx_pkg::fpx_cls_halt;
    end else if (hi == `FPX_SYM_HALT && lo == `FPX_SYM_QUIET) begin
      classify = fpx_pkg::fpx_cls_hq;
    end else if (frame_sym(hi) && frame_sym(lo)) begin
      classify = fpx_pkg::fpx_cls_data;
    end else begin
      classify = fpx_pkg::fpx_cls_noise;
    end
  endfunction : classify

  always_comb begin
    fpx_state_t        n;
    fpx_pkg::fpx_cls_t cls;
    logic              loop_int;
    logic              sd_int;
    logic              wr_ev;
    logic              rd_ev;
    logic [9:0]        wr_pair;
    logic              bus_req;
    logic              bus_wr;
    logic [7:0]        badr;
    logic              known;
    logic              le_err;
    logic              eb_err;
    logic [3:0]        run_len;
    n        = st_reg;
    cls      = classify(st_reg.pair_s2);
    loop_int = st_reg.mode[`FPX_BIT_LOOP_HI:`FPX_BIT_LOOP_LO] == `FPX_LOOP_INTERNAL;
    sd_int   = st_reg.mode[`FPX_BIT_RUN] & (st_reg.sd_s2 | loop_int);
    wr_ev    = loop_int ? st_reg.tx_valid : (st_reg.rxc_s2 & ~st_reg.rxc_s3);
    wr_pair  = loop_int ? st_reg.tx_code : st_reg.pair_s2;
    rd_ev    = st_reg.lbc_s2 & ~st_reg.lbc_s3;
    bus_req  = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
    badr     = {wb_adr_i[7:2], 2'b00};
    known    = 1'b0;
    le_err   = 1'b0;
    eb_err   = 1'b0;
    run_len  = 4'h1;
    if (loop_int) begin
      cls = classify(st_reg.tx_code);
    end

    // Pin synchronisers
    n.rxc_s1  = recovered_rx_clock;
    n.rxc_s2  = st_reg.rxc_s1;
    n.rxc_s3  = st_reg.rxc_s2;
    n.lbc_s1  = local_byte_clock;
    n.lbc_s2  = st_reg.lbc_s1;
    n.lbc_s3  = st_reg.lbc_s2;
    n.sd_s1   = signal_detect;
    n.sd_s2   = st_reg.sd_s1;
    n.pair_s1 = rx_pair_in;
    n.pair_s2 = st_reg.pair_s1;

    // Line state detector
    if (!sd_int) begin
      n.ls        = fpx_pkg::fpx_ls_nosig;
      n.unknown   = 1'b1;
      n.same_cnt  = 4'h0;
      n.noise_cnt = 5'h00;
    end else if (wr_ev) begin
      if (cls == st_reg.last_cls && st_reg.same_cnt != 4'hF) begin
        run_len = st_reg.same_cnt + 4'h1;
      end
      n.same_cnt = run_len;
      n.last_cls = cls;
      case (cls)
        fpx_pkg::fpx_cls_jk: begin
          n.ls  = fpx_pkg::fpx_ls_active;
          known = 1'b1;
        end
        fpx_pkg::fpx_cls_data: begin
          known = st_reg.ls == fpx_pkg::fpx_ls_active;
        end
        fpx_pkg::fpx_cls_idle: begin
          if (run_len >= `FPX_IDLE_PAIRS) begin
            n.ls  = fpx_pkg::fpx_ls_idle;
            known = 1'b1;
          end
        end
        fpx_pkg::fpx_cls_quiet: begin
          if (run_len >= `FPX_QUIET_PAIRS) begin
            n.ls  = fpx_pkg::fpx_ls_quiet;
            known = 1'b1;
          end
        end
        fpx_pkg::fpx_cls_halt: begin
          if (run_len >= `FPX_HALT_PAIRS) begin
            n.ls  = fpx_pkg::fpx_ls_halt;
            known = 1'b1;
          end
        end
        fpx_pkg::fpx_cls_hq: begin
          if (run_len >= `FPX_MASTER_PAIRS) begin
            n.ls  = fpx_pkg::fpx_ls_master;
            known = 1'b1;
          end
        end
        default: begin
          known = 1'b0;
        end
      endcase
      if (known) begin
        n.unknown   = 1'b0;
        n.noise_cnt = 5'h00;
      end else begin
        n.unknown = 1'b1;
        if (cls == fpx_pkg::fpx_cls_noise && st_reg.ls != fpx_pkg::fpx_ls_noise) begin
          n.noise_cnt = st_reg.noise_cnt + 5'h01;
          if (n.noise_cnt >= `FPX_NOISE_PAIRS) begin
            n.ls        = fpx_pkg::fpx_ls_noise;
            n.noise_cnt = 5'h00;
          end
        end
      end
      le_err = cls == fpx_pkg::fpx_cls_noise &&
               (st_reg.ls == fpx_pkg::fpx_ls_active || st_reg.ls == fpx_pkg::fpx_ls_idle);
    end

    // Elasticity buffer write side
    if (wr_ev && sd_int) begin
      if (st_reg.ls == fpx_pkg::fpx_ls_idle && cls == fpx_pkg::fpx_cls_idle &&
          st_reg.fill > (AW+1)'(HALF)) begin
        n.fill = st_reg.fill;
      end else if (st_reg.fill >= (AW+1)'(EB_DEPTH - 1)) begin
        eb_err     = 1'b1;
        n.tag_pend = 1'b1;
      end else begin
        n.mem[st_reg.wp] = {st_reg.tag_pend, wr_pair};
        n.wp             = st_reg.wp + 1'b1;
        n.fill           = st_reg.fill + 1'b1;
        n.tag_pend       = 1'b0;
      end
      if (cls == fpx_pkg::fpx_cls_jk) begin
        n.rp     = n.wp - AW'(HALF);
        n.fill   = (AW+1)'(HALF);
        n.rc_cnt = 2'h0;
      end
    end

    // Elasticity buffer read side
    n.out_valid = 1'b0;
    if (rd_ev) begin
      n.out_valid = 1'b1;
      if (n.fill >= (AW+1)'(2)) begin
        {n.out_tag, n.out_pair} = n.mem[n.rp];
        n.rp   = n.rp + 1'b1;
        n.fill = n.fill - 1'b1;
      end else begin
        n.out_pair = {`FPX_SYM_IDLE, `FPX_SYM_IDLE};
        n.out_tag  = 1'b0;
        if (sd_int && !(st_reg.last_idle && st_reg.ls == fpx_pkg::fpx_ls_idle)) begin
          n.out_tag = 1'b1;
          eb_err    = 1'b1;
        end
      end
      n.last_idle = n.out_pair == {`FPX_SYM_IDLE, `FPX_SYM_IDLE};
      if (st_reg.ls != fpx_pkg::fpx_ls_active) begin
        n.rc_cnt = n.rc_cnt + 2'h1;
        if (n.rc_cnt == 2'h0) begin
          n.rp   = n.wp - AW'(HALF);
          n.fill = (AW+1)'(HALF);
        end
      end else begin
        n.rc_cnt = 2'h0;
      end
    end

    // Bus slave
    n.ack   = bus_req;
    n.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      case (badr)
        `FPX_ADR_MODE:       n.rdata[7:0] = st_reg.mode;
        `FPX_ADR_INT_COND:   n.rdata[7:0] = st_reg.interrupt_condition;
        `FPX_ADR_INT_MASK:   n.rdata[7:0] = st_reg.mask;
        `FPX_ADR_TX_STATE:   n.rdata[7:0] = st_reg.transmit_state_control;
        `FPX_ADR_RX_COND_B:  n.rdata[7:0] = st_reg.receive_condition_b;
        `FPX_ADR_LE_THRESH:  n.rdata[7:0] = st_reg.link_error_threshold;
        `FPX_ADR_LE_COUNT:   n.rdata[7:0] = st_reg.lem;
        `FPX_ADR_LINE_STATE: n.rdata[7:0] = {4'h0, st_reg.unknown, st_reg.ls};
        default:             n.rdata      = 32'h0000_0000;
      endcase
      if (badr == `FPX_ADR_LE_COUNT) begin
        n.lem = `FPX_LE_RELOAD;
      end
    end
    if (bus_wr) begin
      case (badr)
        `FPX_ADR_MODE:      n.mode = wb_dat_i[7:0];
        `FPX_ADR_INT_COND:  n.interrupt_condition  = st_reg.interrupt_condition & ~wb_dat_i[7:0];
        `FPX_ADR_INT_MASK:  n.mask = wb_dat_i[7:0];
        `FPX_ADR_TX_STATE:  n.transmit_state_control = wb_dat_i[7:0];
        `FPX_ADR_RX_COND_B: n.receive_condition_b = st_reg.receive_condition_b & ~wb_dat_i[7:0];
        `FPX_ADR_LE_THRESH: begin
          n.link_error_threshold = wb_dat_i[7:0];
          n.lem  = wb_dat_i[7:0];
        end
        default: n.mode = st_reg.mode;
      endcase
    end

    // Link error monitor, wraps below zero
    if (le_err) begin
      n.lem = n.lem - 8'h01;
      if (n.lem == 8'h00) begin
        n.interrupt_condition[`FPX_BIT_LE_HIT] = 1'b1;
      end
    end
    if (eb_err) begin
      n.receive_condition_b[`FPX_BIT_EB_FLAG] = 1'b1;
    end

    // Transmit data register, parity check and encoder
    n.tx_valid = tx_word_valid;
    n.par_fail = 1'b0;
    if (tx_word_valid) begin
      if (tx_word_in[8]) begin
        n.tx_code = {ctl5(tx_word_in[7:4], 1'b0), ctl5(tx_word_in[3:0], 1'b1)};
      end else begin
        n.tx_code = {enc5(tx_word_in[7:4]), enc5(tx_word_in[3:0])};
      end
      if (st_reg.transmit_state_control[`FPX_BIT_PARITY_EN] && !(^tx_word_in)) begin
        n.par_fail                 = 1'b1;
        n.interrupt_condition[`FPX_BIT_PARITY_ERR] = 1'b1;
      end
    end

    // Output routing by loopback mode
    n.med_valid = 1'b0;
    n.ext_valid = 1'b0;
    case (st_reg.mode[`FPX_BIT_LOOP_HI:`FPX_BIT_LOOP_LO])
      `FPX_LOOP_NORMAL: begin
        n.med_valid = st_reg.tx_valid;
        n.med_code  = st_reg.tx_code;
      end
      `FPX_LOOP_EXTERNAL: begin
        n.ext_valid = st_reg.tx_valid;
        n.ext_code  = st_reg.tx_code;
      end
      default: begin
        n.med_code = st_reg.med_code;
      end
    endcase

    n.irq_n = ~|(n.interrupt_condition & n.mask);
    st_next = n;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg          <= '0;
      st_reg.mode     <= `FPX_RST_MODE;
      st_reg.mask     <= `FPX_RST_INT_MASK;
      st_reg.transmit_state_control     <= `FPX_RST_TX_STATE;
      st_reg.link_error_threshold     <= `FPX_RST_LE_THRESH;
      st_reg.lem      <= `FPX_RST_LE_THRESH;
      st_reg.ls       <= fpx_pkg::fpx_ls_nosig;
      st_reg.unknown  <= 1'b1;
      st_reg.last_cls <= fpx_pkg::fpx_cls_noise;
      st_reg.irq_n    <= 1'b1;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o          = st_reg.rdata;
  assign wb_ack_o          = st_reg.ack;
  assign rx_out_pair       = st_reg.out_pair;
  assign rx_out_tag        = st_reg.out_tag;
  assign rx_out_valid      = st_reg.out_valid;
  assign tx_medium_code    = st_reg.med_code;
  assign tx_medium_valid   = st_reg.med_valid;
  assign tx_ext_loop_code  = st_reg.ext_code;
  assign tx_ext_loop_valid = st_reg.ext_valid;
  assign tx_parity_fail    = st_reg.par_fail;
  assign irq_n             = st_reg.irq_n;
endmodule : fpx_top
